/* hdl/pltc_regs.svh */
`ifndef PLTC_REGS_SVH
`define PLTC_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define PLTC_ADDR_W 12
`define PLTC_CFG_OFF 12'h530
`define PLTC_STATE_OFF 12'h540

// ****************************************
// Field positions
// ****************************************
`define PLTC_COMPAT_BIT 8
`define PLTC_XDIS_BIT 11
`define PLTC_ISC_BIT 14
`define PLTC_RETRAIN_BIT 31

// ****************************************
// Reset values
// ****************************************
`define PLTC_COMPAT_RST 1'h0
`define PLTC_XDIS_RST 1'h0
`define PLTC_ISC_RST_DOWN 1'h0
`define PLTC_ISC_RST_OTHER 1'h1
`define PLTC_ZERO_WORD 32'h0000_0000

// ****************************************
// Timing
// ****************************************
`define PLTC_CLK_MHZ 100
`define PLTC_RETRAIN_DELAY_MS 1
`define PLTC_RETRAIN_DELAY_CYC \
    (`PLTC_RETRAIN_DELAY_MS * 1000 * `PLTC_CLK_MHZ)
`define PLTC_DELAY_W 17

`endif

/* hdl/pltc_pkg.sv */
package pltc_pkg;

    // Port operating mode, as set by the switch configuration
    typedef enum logic {
        PLTC_MODE_DOWNSTREAM,
        PLTC_MODE_OTHER
    } pltc_mode_e;

    // Link training state reported by the LTSSM
    typedef struct packed {
        logic in_detect;
        logic in_l0;
        logic gen2_ok;
    } pltc_ltssm_s;

    // Controls driven toward the LTSSM
    typedef struct packed {
        logic compat_mode;
        logic ts_new_bits_en;
        logic cross_train_en;
        logic speed_change_req;
        logic force_detect;
    } pltc_ctrl_s;

    // Retrain sequencer states
    typedef enum logic [1:0] {
        PLTC_RT_IDLE,
        PLTC_RT_WAIT,
        PLTC_RT_FIRE
    } pltc_rt_e;

endpackage

/* hdl/pltc_delay_timer.sv */
`timescale 1ns/1ps
`include "pltc_regs.svh"

module pltc_delay_timer #(
    parameter int W = `PLTC_DELAY_W
) (
    input logic pclk, // Port core clock
    input logic presetn, // Async reset, active low
    input logic start, // Load and run, one cycle
    input logic [W-1:0] load_val, // Cycles to wait, at least one
    output logic busy_q, // Counting
    output logic done_q // One cycle when count ends
);

    logic [W-1:0] count_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                count_q <= load_val;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (count_q <= W'(1)) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    count_q <= '0;
                end else begin
                    count_q <= count_q - W'(1);
                end
            end
        end
    end

endmodule // pltc_delay_timer

/* hdl/pltc_link_ctrl.sv */
`timescale 1ns/1ps
`include "pltc_regs.svh"

module pltc_link_ctrl
    import pltc_pkg::*;
#(
    parameter int UP_DELAY_CYC = `PLTC_RETRAIN_DELAY_CYC
) (
    input logic pclk, // Port core clock, 100 MHz
    input logic presetn, // Async reset, active low
    input logic psel, // APB select
    input logic penable, // APB access phase
    input logic pwrite, // APB direction, high for write
    input logic [`PLTC_ADDR_W-1:0] paddr, // APB byte address
    input logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB transfer done
    output logic pslverr, // APB unmapped address
    input pltc_mode_e port_mode, // Port operating mode, core clock
    input pltc_ltssm_s ltssm, // LTSSM state, core clock
    output pltc_ctrl_s ctrl, // Controls to the LTSSM
    output logic retrain_busy // Delayed retrain is pending
);

    localparam int DW = `PLTC_DELAY_W;

    // ****************************************
    // Register bus
    // ****************************************
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic compat_q;
    logic xdis_q;
    logic isc_q;
    logic mode_taken_q;
    logic setup;
    logic wr_taken;
    logic hit_cfg;
    logic hit_state;

    function automatic logic [31:0] cfg_word(input logic c,
                                             input logic x,
                                             input logic s);
        logic [31:0] w;
        w = `PLTC_ZERO_WORD;
        w[`PLTC_COMPAT_BIT] = c;
        w[`PLTC_XDIS_BIT] = x;
        w[`PLTC_ISC_BIT] = s;
        return w;
    endfunction

    assign setup = psel && !penable;
    assign hit_cfg = (paddr == `PLTC_CFG_OFF);
    assign hit_state = (paddr == `PLTC_STATE_OFF);
    // completion edge
    // Writes land on the same edge that the master sees pready, so the
    // retrain action can only begin on a later edge.
    assign wr_taken = psel && penable && pready_q && pwrite && !pslverr_q;

    // No wait state, yet read data and pready still come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup && !pready_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !(hit_cfg || hit_state);
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `PLTC_ZERO_WORD;
        end else if (setup && !pwrite && hit_cfg) begin
            prdata_q <= cfg_word(compat_q, xdis_q, isc_q);
        end else begin
            // trigger reads zero
            // Retrain state, reserved bits and unmapped reads give zero
            prdata_q <= `PLTC_ZERO_WORD;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // Configuration bits
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compat_q <= `PLTC_COMPAT_RST;
            xdis_q <= `PLTC_XDIS_RST;
        end else if (wr_taken && hit_cfg) begin
            compat_q <= pwdata[`PLTC_COMPAT_BIT];
            xdis_q <= pwdata[`PLTC_XDIS_BIT];
        end
    end

    // The mode input is not known under reset, so the speed-change
    // control takes its mode-based value at the first edge after release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_taken_q <= 1'b0;
        end else begin
            mode_taken_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isc_q <= `PLTC_ISC_RST_OTHER;
        end else if (!mode_taken_q) begin
            isc_q <= (port_mode == PLTC_MODE_DOWNSTREAM) ?
                `PLTC_ISC_RST_DOWN : `PLTC_ISC_RST_OTHER;
        end else if (wr_taken && hit_cfg) begin
            isc_q <= pwdata[`PLTC_ISC_BIT];
        end
    end

    // ****************************************
    // Full retrain sequencer
    // ****************************************
    pltc_rt_e rt_q;
    logic rt_req;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic force_q;

    assign rt_req = wr_taken && hit_state && pwdata[`PLTC_RETRAIN_BIT];
    assign tmr_start = rt_req && (rt_q == PLTC_RT_IDLE) &&
        (port_mode != PLTC_MODE_DOWNSTREAM);

    pltc_delay_timer #(
        .W(DW)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(tmr_start),
        .load_val(DW'(UP_DELAY_CYC)),
        .busy_q(tmr_busy),
        .done_q(tmr_done)
    );

    // A second trigger while a delayed retrain is pending is absorbed;
    // restarting the wait would let software postpone retrain forever.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_q <= PLTC_RT_IDLE;
        end else begin
            case (rt_q)
                PLTC_RT_IDLE: begin
                    if (tmr_start) begin
                        rt_q <= PLTC_RT_WAIT;
                    end else if (rt_req) begin
                        rt_q <= PLTC_RT_FIRE;
                    end
                end
                PLTC_RT_WAIT: begin
                    if (tmr_done) begin
                        rt_q <= PLTC_RT_FIRE;
                    end
                end
                PLTC_RT_FIRE: begin
                    rt_q <= PLTC_RT_IDLE;
                end
                default: begin
                    rt_q <= PLTC_RT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_q <= 1'b0;
        end else begin
            force_q <= (rt_q == PLTC_RT_FIRE);
        end
    end

    // ****************************************
    // Initial speed change
    // ****************************************
    logic seen_detect_q;
    logic first_l0_done_q;
    logic speed_req_q;
    logic first_l0;

    assign first_l0 = seen_detect_q && !first_l0_done_q && ltssm.in_l0;

    // A full retrain goes back through Detect, so the first-L0 watch
    // is armed again for the new training.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_detect_q <= 1'b0;
        end else if (force_q) begin
            seen_detect_q <= 1'b0;
        end else if (ltssm.in_detect) begin
            seen_detect_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_l0_done_q <= 1'b0;
        end else if (force_q) begin
            first_l0_done_q <= 1'b0;
        end else if (first_l0) begin
            first_l0_done_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_req_q <= 1'b0;
        end else begin
            speed_req_q <= first_l0 && !isc_q && ltssm.gen2_ok;
        end
    end

    // ****************************************
    // Controls to the LTSSM
    // ****************************************
    logic busy_q;
    pltc_ctrl_s ctrl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= tmr_busy;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q.compat_mode <= compat_q;
            ctrl_q.ts_new_bits_en <= !compat_q;
            ctrl_q.cross_train_en <= !xdis_q;
            ctrl_q.speed_change_req <= speed_req_q;
            ctrl_q.force_detect <= force_q;
        end
    end

    assign ctrl = ctrl_q;
    assign retrain_busy = busy_q;

endmodule // pltc_link_ctrl

/* test/pltc_link_ctrl_asserts.sv */
`timescale 1ns/1ps
`include "pltc_regs.svh"
module pltc_link_ctrl_asserts
    import pltc_pkg::*;
#(
    parameter int UP_DELAY_CYC = 20
) (
    input logic pclk, // Clock
    input logic presetn, // Reset
    input logic psel, // Select
    input logic penable, // Access
    input logic pwrite, // Direction
    input logic [`PLTC_ADDR_W-1:0] paddr, // Address
    input logic [31:0] pwdata, // Write data
    input logic [31:0] prdata, // Read data
    input logic pready, // Done
    input logic pslverr, // Error
    input pltc_mode_e port_mode, // Mode
    input pltc_ltssm_s ltssm, // Training state
    input pltc_ctrl_s ctrl, // Controls
    input logic retrain_busy // Pending
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr, wr_cfg, wr_rt1, wr_rt0, isc_q;
    assign wr = psel && penable && pready && pwrite;
    assign wr_cfg = wr && paddr == `PLTC_CFG_OFF;
    assign wr_rt1 = wr && paddr == `PLTC_STATE_OFF && pwdata[31];
    assign wr_rt0 = wr && paddr == `PLTC_STATE_OFF && !pwdata[31];
    // Shadow of the speed-change control, reloaded by each reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isc_q <= port_mode == PLTC_MODE_OTHER;
        end else if (wr_cfg) begin
            isc_q <= pwdata[14];
        end
    end
    // Cycles since an accepted upstream trigger; the pulse ends the count
    logic [31:0] up_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt_q <= '0;
        end else if (ctrl.force_detect) begin
            up_cnt_q <= '0;
        end else if (up_cnt_q != '0) begin
            up_cnt_q <= up_cnt_q + 32'h0000_0001;
        end else if (wr_rt1 && port_mode == PLTC_MODE_OTHER &&
                !retrain_busy) begin
            up_cnt_q <= 32'h0000_0001;
        end
    end
    sequence s_down_fire;
        !ctrl.force_detect [*2] ##1 ctrl.force_detect;
    endsequence
    sequence s_up_hold;
        !ctrl.force_detect [*2] ##1
            (retrain_busy && !ctrl.force_detect) [*8];
    endsequence
    a_compat_level: assert property (
        wr_cfg |=> ##1 ctrl.compat_mode == $past(pwdata[8], 2))
        else $error("compat mode does not follow write");
    a_compat_ts_clear: assert property (
        ctrl.compat_mode |-> !ctrl.ts_new_bits_en)
        else $error("new training bits set in compat mode");
    a_cross_disable: assert property (
        wr_cfg |=> ##1 ctrl.cross_train_en == !$past(pwdata[11], 2))
        else $error("crosslink enable does not follow write");
    a_no_auto_speed: assert property (
        isc_q |-> !ctrl.speed_change_req)
        else $error("speed change with control at one");
    a_down_fire: assert property (
        wr_rt1 && port_mode == PLTC_MODE_DOWNSTREAM |=> s_down_fire)
        else $error("downstream retrain pulse misplaced");
    a_trigger_reads_zero: assert property (
        pready && !pwrite && paddr == `PLTC_STATE_OFF |-> prdata == '0)
        else $error("retrain trigger read nonzero");
    a_up_hold: assert property (
        wr_rt1 && port_mode == PLTC_MODE_OTHER && !retrain_busy
        |=> s_up_hold)
        else $error("upstream retrain not delayed");
    a_up_delay_exact: assert property (
        ctrl.force_detect && port_mode == PLTC_MODE_OTHER
        |-> up_cnt_q == UP_DELAY_CYC + 4)
        else $error("upstream retrain delay not exact");
    a_zero_write: assert property (
        wr_rt0 && !retrain_busy && !ctrl.force_detect
        |=> !ctrl.force_detect [*4])
        else $error("zero write caused retrain");
endmodule // pltc_link_ctrl_asserts

bind pltc_link_ctrl pltc_link_ctrl_asserts #(
    .UP_DELAY_CYC(UP_DELAY_CYC)
) pltc_link_ctrl_asserts_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_mode(port_mode), .ltssm(ltssm),
    .ctrl(ctrl), .retrain_busy(retrain_busy));

/* test/pltc_ltssm_model.sv */
`timescale 1ns/1ps
module pltc_ltssm_model
    import pltc_pkg::*;
(
    input logic pclk, // Clock
    input logic presetn, // Reset
    input pltc_ctrl_s ctrl, // Controls from the port
    input logic gen2_ok, // Far end offers Gen2
    input logic slow, // Long training
    output pltc_ltssm_s ltssm // Training state
);
    // ****************************************
    // Detect then L0, restarted by force
    // ****************************************
    logic [3:0] cnt_q;
    logic [3:0] lim;
    assign lim = slow ? 4'hc : 4'h2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            ltssm <= '0;
        end else begin
            cnt_q <= ctrl.force_detect ? 4'h0 :
                cnt_q + {3'h0, cnt_q != 4'hf};
            ltssm <= '{cnt_q < lim, cnt_q >= lim, gen2_ok};
        end
    end
endmodule // pltc_ltssm_model

/* test/pltc_link_ctrl_tb.sv */
`timescale 1ns/1ps
`include "pltc_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pltc_link_ctrl_tb
    import pltc_pkg::*;
;
    // ****************************************
    // Bench
    // ****************************************
    localparam int UP = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, gen2_ok = 1'b1, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = '0, prdata, d;
    logic pready, pslverr, retrain_busy;
    pltc_mode_e port_mode = PLTC_MODE_DOWNSTREAM;
    pltc_ltssm_s ltssm;
    pltc_ctrl_s ctrl;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int checked = 0, bad_count = 0, fd_cnt = 0, sc_cnt = 0, n, f, s, g;
    always #5 pclk = ~pclk;
    pltc_link_ctrl #(.UP_DELAY_CYC(UP)) pltc_link_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_mode(port_mode),
        .ltssm(ltssm), .ctrl(ctrl), .retrain_busy(retrain_busy));
    pltc_ltssm_model pltc_ltssm_model_inst (.pclk(pclk),
        .presetn(presetn), .ctrl(ctrl), .gen2_ok(gen2_ok), .slow(slow),
        .ltssm(ltssm));
    always @(posedge pclk) begin
        fd_cnt <= fd_cnt + ctrl.force_detect;
        sc_cnt <= sc_cnt + ctrl.speed_change_req;
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            `CHK("read", e, {pslverr, prdata})
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] v, input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        if (!w) exp_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_fd(output int c);
        c = 0;
        f = fd_cnt;
        while (fd_cnt == f && c < 60) begin
            @(posedge pclk);
            #1 c++;
        end
    endtask
    task automatic do_reset(input pltc_mode_e m);
        port_mode <= m;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Far longer than the whole sequence needs
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(8));
        do_reset(PLTC_MODE_DOWNSTREAM);
        apb(1'b0, `PLTC_CFG_OFF, '0, '0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            apb(1'b1, `PLTC_CFG_OFF, d, '0);
            @(posedge pclk);
            #1 `CHK("compat", d[8], ctrl.compat_mode)
            `CHK("ts_bits", !d[8], ctrl.ts_new_bits_en)
            `CHK("cross", !d[11], ctrl.cross_train_en)
            apb(1'b0, `PLTC_CFG_OFF, '0, {1'b0, d & 32'h0000_4900});
        end
        $display("config test done");
        for (int k = 0; k < 3; k++) begin
            gen2_ok <= k != 1;
            slow <= k[0];
            apb(1'b1, `PLTC_CFG_OFF, {17'h0_0000, k == 2, 14'h0000}, '0);
            s = sc_cnt;
            apb(1'b1, `PLTC_STATE_OFF, 32'h8000_0000, '0);
            wait_fd(n);
            `CHK("fd_delay", 3, n)
            repeat (30) @(posedge pclk);
            `CHK("speed", k == 0, sc_cnt - s)
        end
        $display("downstream retrain test done");
        s = fd_cnt;
        apb(1'b1, `PLTC_STATE_OFF, 32'h7fff_ffff, '0);
        repeat (20) @(posedge pclk);
        `CHK("zero_wr", 0, fd_cnt - s)
        apb(1'b0, `PLTC_STATE_OFF, '0, '0);
        apb(1'b0, 12'h100, '0, 33'h1_0000_0000);
        $display("access test done");
        g = sc_cnt;
        do_reset(PLTC_MODE_OTHER);
        apb(1'b0, `PLTC_CFG_OFF, '0, 33'h0_0000_4000);
        s = fd_cnt;
        apb(1'b1, `PLTC_STATE_OFF, 32'h8000_0000, '0);
        apb(1'b1, `PLTC_STATE_OFF, 32'hffff_ffff, '0);
        #1 `CHK("busy", 1'b1, retrain_busy)
        wait_fd(n);
        `CHK("up_delay", UP + 1, n)
        repeat (30) @(posedge pclk);
        `CHK("up_once", 1, fd_cnt - s)
        `CHK("no_speed", 0, sc_cnt - g)
        $display("upstream retrain test done");
        stop_test();
    end
endmodule // pltc_link_ctrl_tb
